// >>> spps_pkg.sv
/*
  Constants shared by the serial programming port sequencer: command codes,
  serial frame lengths, bulk erase keys, register offsets and field positions.
  Assumes a 22-bit table address space and an 8-bit register port.
*/
`default_nettype none
package spps_pkg;
  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  localparam logic [4:0] SER_CMD_BITS = 5'h04;
  localparam logic [4:0] SER_TURN_BITS = 5'h0C;
  localparam logic [4:0] SER_FRAME_BITS = 5'h14;
  localparam logic [4:0] SER_LAST_BIT = 5'h13;
  localparam logic [4:0] SER_HOLD_RISE = 5'h03;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_CORE = 4'h0;
  localparam logic [3:0] CMD_SHIFT_LATCH = 4'h2;
  localparam logic [3:0] CMD_RD = 4'h8;
  localparam logic [3:0] CMD_RD_POSTINC = 4'h9;
  localparam logic [3:0] CMD_RD_POSTDEC = 4'hA;
  localparam logic [3:0] CMD_RD_PREINC = 4'hB;
  localparam logic [3:0] CMD_WR = 4'hC;
  localparam logic [3:0] CMD_WR_INC2 = 4'hD;
  localparam logic [3:0] CMD_PROG_INC2 = 4'hE;
  localparam logic [3:0] CMD_PROG = 4'hF;
  // ----------------------------------------------------------------
  // Addresses and keys
  // ----------------------------------------------------------------
  localparam int PTR_W = 22;
  localparam logic [21:0] PTR_ZERO = 22'h000000;
  localparam logic [21:0] PTR_ONE = 22'h000001;
  localparam logic [21:0] PTR_TWO = 22'h000002;
  localparam logic [21:0] ROW_MASK = 22'h3FFFC0;
  localparam logic [21:0] BULK_KEY1_ADDR = 22'h3C0005;
  localparam logic [15:0] BULK_KEY1_DATA = 16'h3F3F;
  localparam logic [21:0] BULK_KEY2_ADDR = 22'h3C0004;
  localparam logic [15:0] BULK_KEY2_DATA = 16'h8F8F;
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PTR_LO = 8'h00;
  localparam logic [7:0] REG_PTR_HI = 8'h04;
  localparam logic [7:0] REG_PTR_UP = 8'h08;
  localparam logic [7:0] REG_LATCH = 8'h0C;
  localparam logic [7:0] REG_MEMCTL = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam int MC_FLASH_SEL = 7;
  localparam int MC_CONFIG_SEL = 6;
  localparam int MC_ERASE_SEL = 4;
  localparam int MC_WRITE_EN = 2;
  localparam int MC_WRITE_START = 1;
  localparam logic [7:0] MEMCTL_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  typedef enum logic [1:0] {SPPS_SEL_NONE, SPPS_SEL_DEF, SPPS_SEL_ALT} spps_sel_t;
endpackage
`default_nettype wire

// >>> spps_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to clk_in and are single-bit levels.
*/
`timescale 1ns/1ps
`default_nettype none
module spps_sync
  import spps_pkg::*;
#(
  parameter int WIDTH = 6
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } spps_sync_t;
  spps_sync_t q;
  spps_sync_t next_q;
  always_comb begin
    next_q.meta = async_in;
    next_q.stable = q.meta;
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign sync_out = q.stable;
endmodule
`default_nettype wire

// >>> spps_ptr_calc.sv
/*
  Table pointer arithmetic for table reads and writes.
  Assumes the caller applies the new pointer once per command: at the read turnaround, or when a write completes.
*/
`timescale 1ns/1ps
`default_nettype none
module spps_ptr_calc
  import spps_pkg::*;
(
  input wire logic [3:0] cmd_in,
  input wire logic [21:0] ptr_in,
  input wire logic [21:0] code_top_in,
  output logic [21:0] read_addr_out,
  output logic [21:0] next_ptr_out
);
  always_comb begin
    read_addr_out = ptr_in;
    next_ptr_out = ptr_in;
    case (cmd_in)
      CMD_RD_POSTINC: begin
        // Wrapping keeps a verify loop from walking into unimplemented space.
        next_ptr_out = (ptr_in == code_top_in) ? PTR_ZERO : ptr_in + PTR_ONE;
      end
      CMD_RD_POSTDEC: begin
        next_ptr_out = ptr_in - PTR_ONE;
      end
      CMD_RD_PREINC: begin
        next_ptr_out = ptr_in + PTR_ONE;
        read_addr_out = ptr_in + PTR_ONE;
      end
      CMD_WR_INC2, CMD_PROG_INC2: begin
        next_ptr_out = ptr_in + PTR_TWO;
      end
      default: begin
        next_ptr_out = ptr_in;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> spps_top.sv
/*
  Serial programming port sequencer: two pin groups, command shifter,
  table pointer and latch, timed erase and program control, register port.
  Assumes the core executes injected instructions and writes the pointer,
  latch and control registers back through the register port, and that the
  flash array answers a read strobe with data on the following cycle.
*/
// Operation
// - Programmer clocks serial data; bits sampled on falling edge, LSb first.
// - Each transaction is 20 bits: 4-bit command then 16-bit operand.
// - Operand is 16 bits in, or 8 bits in then 8 bits out.
// - Command 0000 hands the 16-bit operand to the core as instruction.
// - 0010 shifts latch out; 1000-1011 read with pointer hold, inc, dec, pre-inc.
// - 1100 writes with pointer held; 1101 writes then adds two.
// - 1110 writes, starts programming, adds two; 1111 writes and starts.
// - Dedicated pins carry the same protocol when the port enable is set.
// - Default pins keep working while the dedicated port is enabled.
// - First high-voltage enable seen selects the port; the other is ignored.
// - Port enable writable only from default port; alternate erase keeps it.
// - Single 64-byte aligned row erase, refused for protected rows.
// - After write start, fourth clock of a no-op held high times the operation.
// - Operation ends when the clock falls; programmer then keeps clock low.
// - Row erase hits the row holding the pointer, any byte within it.
// - Buffer loaded with two-byte post-increment writes; last one starts programming.
// - Read turnaround after eighth operand clock; byte out on last eight, LSb first.
// - Post-increment read at top of code memory wraps pointer to zero.
`timescale 1ns/1ps
`default_nettype none
module spps_top
  import spps_pkg::*;
#(
  parameter logic [21:0] CODE_TOP = 22'h00FFFF
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic hv_enable_pin_in,
  input wire logic alt_hv_enable_pin_in,
  input wire logic prog_clock_pin_in,
  input wire logic prog_data_pin_in,
  output logic prog_data_pin_out,
  output logic prog_data_pin_oe_out,
  input wire logic alt_prog_clock_pin_in,
  input wire logic alt_prog_data_pin_in,
  output logic alt_prog_data_pin_out,
  output logic alt_prog_data_pin_oe_out,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic [15:0] core_instr_out,
  output logic core_instr_valid_out,
  output logic [21:0] flash_addr_out,
  output logic [15:0] flash_wdata_out,
  output logic flash_wr_out,
  output logic flash_rd_out,
  input wire logic [7:0] flash_rdata_in,
  input wire logic row_protected_in,
  output logic flash_prog_out,
  output logic flash_row_erase_out,
  output logic flash_bulk_erase_out,
  output logic dedicated_port_enable_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    spps_sel_t sel;
    logic clk_d;
    logic [4:0] cnt;
    logic [3:0] cmd;
    logic [15:0] opr;
    logic [21:0] ptr;
    logic [7:0] latch;
    logic [7:0] memctl;
    logic port_en;
    logic armed;
    logic pend;
    logic busy;
    logic refused;
    logic rd_pend;
    logic dout;
    logic doe;
    logic def_oe;
    logic alt_oe;
    logic [15:0] core_instr;
    logic core_valid;
    logic [21:0] fl_addr;
    logic [15:0] fl_wdata;
    logic fl_wr;
    logic fl_rd;
    logic fl_prog;
    logic fl_row;
    logic fl_bulk;
    logic [7:0] rdata;
  } spps_state_t;
  spps_state_t q;
  spps_state_t next_q;
  logic [5:0] pins_s;
  logic hv_s;
  logic ahv_s;
  logic ck;
  logic dt;
  logic rise;
  logic fall;
  logic [21:0] calc_raddr;
  logic [21:0] calc_nptr;
  logic is_read;
  logic [4:0] out_idx;
  // ----------------------------------------------------------------
  // Pin synchronisers and port mux
  // ----------------------------------------------------------------
  spps_sync #(.WIDTH(6)) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in({hv_enable_pin_in, alt_hv_enable_pin_in, prog_clock_pin_in,
               prog_data_pin_in, alt_prog_clock_pin_in, alt_prog_data_pin_in}),
    .sync_out(pins_s)
  );
  assign hv_s = pins_s[5];
  assign ahv_s = pins_s[4];
  // Both pin groups feed one shifter, so the two ports shift identically; only the default port changes the port enable.
  assign ck = (q.sel == SPPS_SEL_ALT) ? pins_s[1] : pins_s[3];
  assign dt = (q.sel == SPPS_SEL_ALT) ? pins_s[0] : pins_s[2];
  assign rise = ck & ~q.clk_d & (q.sel != SPPS_SEL_NONE);
  assign fall = ~ck & q.clk_d & (q.sel != SPPS_SEL_NONE);
  assign is_read = q.cmd[3] & ~q.cmd[2];
  assign out_idx = q.cnt - SER_TURN_BITS;
  spps_ptr_calc u_ptr (
    .cmd_in(q.cmd),
    .ptr_in(q.ptr),
    .code_top_in(CODE_TOP),
    .read_addr_out(calc_raddr),
    .next_ptr_out(calc_nptr)
  );
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.clk_d = ck;
    next_q.core_valid = 1'b0;
    next_q.fl_wr = 1'b0;
    next_q.fl_rd = 1'b0;
    next_q.fl_bulk = 1'b0;
    next_q.rd_pend = q.fl_rd;
    // The first enable to reach high voltage owns the session until it drops.
    case (q.sel)
      SPPS_SEL_NONE: begin
        if (hv_s) begin
          next_q.sel = SPPS_SEL_DEF;
        end else if (ahv_s && q.port_en) begin
          next_q.sel = SPPS_SEL_ALT;
        end
        next_q.cnt = '0;
        next_q.doe = 1'b0;
      end
      SPPS_SEL_DEF: begin
        if (!hv_s) begin
          next_q.sel = SPPS_SEL_NONE;
        end
      end
      SPPS_SEL_ALT: begin
        if (!ahv_s) begin
          next_q.sel = SPPS_SEL_NONE;
        end
      end
      default: begin
        next_q.sel = SPPS_SEL_NONE;
      end
    endcase
    if (q.rd_pend && q.sel != SPPS_SEL_NONE) begin
      next_q.latch = flash_rdata_in;
      next_q.dout = flash_rdata_in[0];
      next_q.doe = 1'b1;
    end
    if (rise) begin
      if (q.pend && q.cnt == SER_HOLD_RISE) begin
        // The held-high fourth clock times the erase or program pulse.
        if (q.memctl[MC_WRITE_EN]) begin
          if (q.memctl[MC_ERASE_SEL]) begin
            if (row_protected_in) begin
              next_q.refused = 1'b1;
            end else begin
              next_q.fl_row = 1'b1;
              next_q.busy = 1'b1;
              next_q.fl_addr = q.ptr & ROW_MASK;
            end
          end else begin
            next_q.fl_prog = 1'b1;
            next_q.busy = 1'b1;
            next_q.fl_addr = q.ptr;
          end
        end else begin
          next_q.refused = 1'b1;
        end
      end
      if (q.doe && q.cnt > SER_TURN_BITS) begin
        next_q.dout = q.latch[out_idx[2:0]];
      end
    end
    if (fall) begin
      if (q.busy || q.refused) begin
        next_q.busy = 1'b0;
        next_q.fl_prog = 1'b0;
        next_q.fl_row = 1'b0;
        next_q.pend = 1'b0;
        next_q.memctl[MC_WRITE_START] = 1'b0;
        next_q.refused = 1'b0;
      end
      next_q.cnt = q.cnt + 5'h01;
      if (q.cnt < SER_CMD_BITS) begin
        next_q.cmd[q.cnt[1:0]] = dt;
      end else begin
        next_q.opr[q.cnt[3:0] - SER_CMD_BITS[3:0]] = dt;
      end
      if (q.cnt == SER_TURN_BITS - 5'h01 && (is_read || q.cmd == CMD_SHIFT_LATCH)) begin
        // Read happens in the turnaround gap so the byte is ready to drive.
        if (is_read) begin
          next_q.fl_rd = 1'b1;
          next_q.fl_addr = calc_raddr;
          next_q.ptr = calc_nptr;
        end else begin
          next_q.dout = q.latch[0];
          next_q.doe = 1'b1;
        end
      end
      if (q.cnt == SER_LAST_BIT) begin
        next_q.cnt = '0;
        next_q.doe = 1'b0;
        if (q.cmd == CMD_CORE) begin
          next_q.core_instr = {dt, q.opr[14:0]};
          next_q.core_valid = 1'b1;
        end else if (q.cmd[3] & q.cmd[2]) begin
          next_q.fl_wr = 1'b1;
          next_q.fl_addr = q.ptr;
          next_q.fl_wdata = {dt, q.opr[14:0]};
          next_q.ptr = calc_nptr;
          if (q.cmd[1]) begin
            next_q.pend = 1'b1;
          end
          if (q.cmd == CMD_WR) begin
            if (q.ptr == BULK_KEY1_ADDR && {dt, q.opr[14:0]} == BULK_KEY1_DATA) begin
              next_q.armed = 1'b1;
            end else if (q.armed && q.ptr == BULK_KEY2_ADDR
                         && {dt, q.opr[14:0]} == BULK_KEY2_DATA) begin
              next_q.armed = 1'b0;
              next_q.fl_bulk = 1'b1;
              if (q.sel == SPPS_SEL_DEF) begin
                next_q.port_en = 1'b0;
              end
            end else begin
              next_q.armed = 1'b0;
            end
          end
        end
      end
    end
    // Register port: the core writes back what the injected instructions set.
    if (reg_wr_in) begin
      if (reg_addr_in == REG_PTR_LO) begin
        next_q.ptr[7:0] = reg_wdata_in;
      end else if (reg_addr_in == REG_PTR_HI) begin
        next_q.ptr[15:8] = reg_wdata_in;
      end else if (reg_addr_in == REG_PTR_UP) begin
        next_q.ptr[21:16] = reg_wdata_in[5:0];
      end else if (reg_addr_in == REG_LATCH) begin
        next_q.latch = reg_wdata_in;
      end else if (reg_addr_in == REG_MEMCTL) begin
        next_q.memctl = reg_wdata_in;
        if (reg_wdata_in[MC_WRITE_START]) begin
          next_q.pend = 1'b1;
        end
      end else if (reg_addr_in == REG_CONFIG) begin
        if (q.sel == SPPS_SEL_DEF) begin
          next_q.port_en = reg_wdata_in[0];
        end
      end
    end
    next_q.rdata = BYTE_ZERO;
    if (reg_rd_in) begin
      if (reg_addr_in == REG_PTR_LO) begin
        next_q.rdata = q.ptr[7:0];
      end else if (reg_addr_in == REG_PTR_HI) begin
        next_q.rdata = q.ptr[15:8];
      end else if (reg_addr_in == REG_PTR_UP) begin
        next_q.rdata = {2'h0, q.ptr[21:16]};
      end else if (reg_addr_in == REG_LATCH) begin
        next_q.rdata = q.latch;
      end else if (reg_addr_in == REG_MEMCTL) begin
        next_q.rdata = q.memctl;
      end else if (reg_addr_in == REG_CONFIG) begin
        next_q.rdata = {7'h00, q.port_en};
      end else if (reg_addr_in == REG_STATUS) begin
        next_q.rdata = {2'h0, q.refused, q.busy, q.pend, q.armed, q.sel};
      end
    end
    next_q.def_oe = next_q.doe && (next_q.sel == SPPS_SEL_DEF);
    next_q.alt_oe = next_q.doe && (next_q.sel == SPPS_SEL_ALT);
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.memctl <= MEMCTL_RST;
    end else begin
      q <= next_q;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prog_data_pin_out = q.dout;
  assign prog_data_pin_oe_out = q.def_oe;
  assign alt_prog_data_pin_out = q.dout;
  assign alt_prog_data_pin_oe_out = q.alt_oe;
  assign reg_rdata_out = q.rdata;
  assign core_instr_out = q.core_instr;
  assign core_instr_valid_out = q.core_valid;
  assign flash_addr_out = q.fl_addr;
  assign flash_wdata_out = q.fl_wdata;
  assign flash_wr_out = q.fl_wr;
  assign flash_rd_out = q.fl_rd;
  assign flash_prog_out = q.fl_prog;
  assign flash_row_erase_out = q.fl_row;
  assign flash_bulk_erase_out = q.fl_bulk;
  assign dedicated_port_enable_out = q.port_en;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_idle_no_drive: assert property ((q.sel == SPPS_SEL_NONE) |=> !q.doe)
    else $error("Data pin driven with no port selected.");
  a_core_from_cmd: assert property (q.core_valid |-> q.cmd == CMD_CORE && q.cnt == 5'h00 ##1
                                    !q.core_valid)
    else $error("Core instruction pulse wrong.");
  a_postinc_step: assert property (($rose(q.fl_rd) && q.cmd == CMD_RD_POSTINC
                                    && $past(q.ptr) != CODE_TOP && !$past(reg_wr_in))
                                   |-> q.ptr == $past(q.ptr) + PTR_ONE)
    else $error("Post-increment read did not advance pointer by one.");
  a_postinc_wrap: assert property (($rose(q.fl_rd) && q.cmd == CMD_RD_POSTINC
                                    && $past(q.ptr) == CODE_TOP && !$past(reg_wr_in))
                                   |-> q.ptr == PTR_ZERO)
    else $error("Pointer did not wrap at top of code memory.");
  a_write_inc2: assert property (($rose(q.fl_wr) && q.cmd == CMD_WR_INC2 && !$past(reg_wr_in))
                                 |-> q.ptr == $past(q.ptr) + PTR_TWO)
    else $error("Write with increment did not add two.");
  a_prog_write_enable_bit: assert property ($rose(q.busy) |-> q.memctl[MC_WRITE_EN])
    else $error("Timed write started without write enable.");
  a_prog_ends: assert property ((q.busy && fall) |=> !q.busy && !q.fl_prog && !q.fl_row)
    else $error("Timed operation outlived the clock fall.");
  a_row_protect: assert property ($rose(q.fl_row) |-> !$past(row_protected_in)
                                  && q.fl_addr[5:0] == 6'h00)
    else $error("Protected or unaligned row erased.");
  a_alt_keeps_en: assert property ((q.sel == SPPS_SEL_ALT && $past(q.sel) == SPPS_SEL_ALT)
                                   |-> q.port_en == $past(q.port_en))
    else $error("Port enable changed from dedicated port.");
  a_read_turn: assert property ($rose(q.fl_rd) |=> ##1 q.doe && q.dout == q.latch[0])
    else $error("Read byte not driven after turnaround.");
  c_core_instr: cover property (q.core_valid);
  c_bulk_erase: cover property (q.fl_bulk);
  c_row_erase: cover property (q.fl_row ##[1:1000] !q.fl_row);
  c_read_out: cover property (q.fl_rd ##[1:1000] q.doe);
endmodule
`default_nettype wire

// >>> spps_top_note_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> spps_prog_model.sv
/*
  Behavioural programmer that clocks 20-bit frames into one serial port.
  Assumes the device's data output and enable are fed back to it.
*/
`timescale 1ns/1ps
`default_nettype none
module spps_prog_model
  import spps_pkg::*;
#(
  parameter int HALF = 4,
  parameter int TURN = 16
) (
  input wire logic clk_in,
  input wire logic dev_data_in,
  input wire logic dev_oe_in,
  output logic clock_out,
  output logic data_out
);
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic drv = 1'b0;
  logic bit_q = 1'b0;
  logic last_q = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  initial clock_out = 1'b0;
  // A released line shows the inverse of its last value, not a stale copy.
  assign data_out = dev_oe_in ? dev_data_in : (drv ? bit_q : ~last_q);
  always @(posedge clk_in) if (drv) last_q <= bit_q;
  // Bits change with each rise and stand through the fall, LSb first.
  task automatic frame(input logic [3:0] cmd, input logic [15:0] opd, input int hold);
    logic [19:0] bits;
    logic rd;
    bits = {opd, cmd};
    rd = (cmd == CMD_SHIFT_LATCH) || (cmd[3:2] == 2'b10);
    @(posedge clk_in);
    for (int i = 0; i < 20; i++) begin
      clock_out <= 1'b1;
      drv <= !(rd && i >= 12);
      bit_q <= bits[i];
      repeat ((i == 3) ? HALF + hold : HALF) @(posedge clk_in);
      // Sample before the fall, while the device still drives.
      if (rd && i >= 12) rd_byte[i-12] = data_out;
      clock_out <= 1'b0;
      repeat ((rd && i == 11) ? TURN : ((i == 3 && hold > 0) ? HALF + hold : HALF))
        @(posedge clk_in);
    end
    drv <= 1'b0;
    repeat (HALF) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench for the serial programming port sequencer.
  Assumes the bench plays core, flash array and register master.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import spps_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk_in = 1'b0, rst_b_in = 1'b0, hv_enable_pin_in = 1'b0, alt_hv_enable_pin_in = 1'b0;
  logic prog_clock_pin_in, prog_data_pin_in, prog_data_pin_out, prog_data_pin_oe_out;
  logic alt_prog_clock_pin_in, alt_prog_data_pin_in, alt_prog_data_pin_out;
  logic alt_prog_data_pin_oe_out, reg_wr_in = 1'b0, reg_rd_in = 1'b0, row_protected_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, flash_rdata_in = 8'h00;
  logic [15:0] core_instr_out, flash_wdata_out;
  logic [21:0] flash_addr_out, last_core = 22'h0, wr_a = 22'h0, wr_d = 22'h0, er_a = 22'h0;
  logic core_instr_valid_out, flash_wr_out, flash_rd_out, flash_prog_out, pq = 1'b0;
  logic flash_row_erase_out, flash_bulk_erase_out, dedicated_port_enable_out, eq = 1'b0;
  int failures = 0, checks = 0, n_bulk = 0, n_prog = 0, n_er = 0, cyc = 0;
  logic [21:0] ea [4];
  logic [21:0] ep [4];
  logic [3:0] rc [4];
  localparam logic [21:0] CODE_TOP_TB = 22'h00FFFF;
  always #10 clk_in = ~clk_in;
  spps_top u_spps_top (.clk_in, .rst_b_in, .hv_enable_pin_in, .alt_hv_enable_pin_in,
    .prog_clock_pin_in, .prog_data_pin_in, .prog_data_pin_out, .prog_data_pin_oe_out,
    .alt_prog_clock_pin_in, .alt_prog_data_pin_in, .alt_prog_data_pin_out,
    .alt_prog_data_pin_oe_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .core_instr_out, .core_instr_valid_out, .flash_addr_out, .flash_wdata_out,
    .flash_wr_out, .flash_rd_out, .flash_rdata_in, .row_protected_in, .flash_prog_out,
    .flash_row_erase_out, .flash_bulk_erase_out, .dedicated_port_enable_out);
  spps_prog_model u_spps_prog_model (.clk_in, .dev_data_in(prog_data_pin_out),
    .dev_oe_in(prog_data_pin_oe_out), .clock_out(prog_clock_pin_in),
    .data_out(prog_data_pin_in));
  spps_prog_model u_spps_prog_model_alt (.clk_in, .dev_data_in(alt_prog_data_pin_out),
    .dev_oe_in(alt_prog_data_pin_oe_out), .clock_out(alt_prog_clock_pin_in),
    .data_out(alt_prog_data_pin_in));
  // ----------------------------------------------------------------
  // Flash, core and timeout monitor
  // ----------------------------------------------------------------
  // Read data is invalid except in the cycle after a read strobe.
  always @(posedge clk_in) begin
    flash_rdata_in <= flash_rd_out ? (flash_addr_out[7:0] ^ 8'h5A) : ~flash_rdata_in;
    pq <= flash_prog_out;
    eq <= flash_row_erase_out;
    if (core_instr_valid_out) last_core <= {6'h00, core_instr_out};
    if (flash_wr_out) wr_a <= flash_addr_out;
    if (flash_wr_out) wr_d <= {6'h00, flash_wdata_out};
    if (flash_bulk_erase_out) n_bulk <= n_bulk + 1;
    if (flash_prog_out && !pq) n_prog <= n_prog + 1;
    if (flash_row_erase_out && !eq) n_er <= n_er + 1;
    if (flash_row_erase_out && !eq) er_a <= flash_addr_out;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t byte got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_val(input logic [21:0] g, input logic [21:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t value got %h expected %h", $time, g, e);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(posedge clk_in);
    cmp_byte(reg_rdata_out, e);
  endtask
  task automatic set_ptr(input logic [21:0] p);
    reg_wr(REG_PTR_LO, p[7:0]);
    reg_wr(REG_PTR_HI, p[15:8]);
    reg_wr(REG_PTR_UP, {2'b00, p[21:16]});
  endtask
  task automatic pins(input logic d, input logic a);
    @(posedge clk_in);
    hv_enable_pin_in <= d;
    alt_hv_enable_pin_in <= a;
    repeat (8) @(posedge clk_in);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rc = '{CMD_RD, CMD_RD_POSTINC, CMD_RD_POSTDEC, CMD_RD_PREINC};
    ea = '{22'h002345, 22'h002345, 22'h002345, 22'h002346};
    ep = '{22'h002345, 22'h002346, 22'h002344, 22'h002346};
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    reg_chk(REG_STATUS, 8'h00);
    reg_chk(REG_MEMCTL, MEMCTL_RST);
    reg_wr(8'hFC, 8'hFF);
    reg_chk(8'hFC, BYTE_ZERO);
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
    reg_chk(REG_STATUS, 8'h01);
    u_spps_prog_model.frame(CMD_CORE, 16'hA5C3, 0);
    cmp_val(last_core, 22'h00A5C3);
    set_ptr(22'h001234);
    u_spps_prog_model.frame(CMD_WR_INC2, 16'h3C40, 0);
    cmp_val(wr_a, 22'h001234);
    cmp_val(wr_d, 22'h003C40);
    reg_chk(REG_PTR_LO, 8'h36);
    for (int i = 0; i < 4; i++) begin
      set_ptr(22'h002345);
      u_spps_prog_model.frame(rc[i], 16'h0000, 0);
      cmp_byte(u_spps_prog_model.rd_byte, ea[i][7:0] ^ 8'h5A);
      reg_chk(REG_PTR_LO, ep[i][7:0]);
    end
    set_ptr(CODE_TOP_TB);
    u_spps_prog_model.frame(CMD_RD_POSTINC, 16'h0000, 0);
    reg_chk(REG_PTR_HI, BYTE_ZERO);
    reg_wr(REG_LATCH, 8'h96);
    u_spps_prog_model.frame(CMD_SHIFT_LATCH, 16'h0000, 0);
    cmp_byte(u_spps_prog_model.rd_byte, 8'h96);
    reg_wr(REG_MEMCTL, 8'h84);
    set_ptr(22'h000100);
    u_spps_prog_model.frame(CMD_WR_INC2, 16'h1122, 0);
    u_spps_prog_model.frame(CMD_PROG, 16'h3344, 0);
    u_spps_prog_model.frame(CMD_CORE, 16'h0000, 40);
    cmp_val(22'(n_prog), 22'h1);
    cmp_val(wr_a, 22'h000102);
    reg_wr(REG_MEMCTL, 8'h80);
    u_spps_prog_model.frame(CMD_PROG_INC2, 16'h5566, 0);
    u_spps_prog_model.frame(CMD_CORE, 16'h0000, 40);
    cmp_val(22'(n_prog), 22'h1);
    set_ptr(22'h000147);
    reg_wr(REG_MEMCTL, 8'h96);
    u_spps_prog_model.frame(CMD_CORE, 16'h0000, 40);
    cmp_val(22'(n_er), 22'h1);
    cmp_val(er_a, 22'h000140);
    row_protected_in <= 1'b1;
    reg_wr(REG_MEMCTL, 8'h96);
    u_spps_prog_model.frame(CMD_CORE, 16'h0000, 40);
    cmp_val(22'(n_er), 22'h1);
    row_protected_in <= 1'b0;
    reg_wr(REG_CONFIG, 8'h01);
    for (int k = 0; k < 2; k++) begin
      set_ptr(BULK_KEY1_ADDR);
      if (k == 0) u_spps_prog_model.frame(CMD_WR, BULK_KEY1_DATA, 0);
      else u_spps_prog_model_alt.frame(CMD_WR, BULK_KEY1_DATA, 0);
      set_ptr(BULK_KEY2_ADDR);
      if (k == 0) u_spps_prog_model.frame(CMD_WR, BULK_KEY2_DATA, 0);
      else u_spps_prog_model_alt.frame(CMD_WR, BULK_KEY2_DATA, 0);
      cmp_val(22'(n_bulk), 22'(k + 1));
      reg_chk(REG_CONFIG, {7'h00, k[0]});
      cmp_val(22'(dedicated_port_enable_out), 22'(k));
      if (k == 0) begin
        reg_wr(REG_CONFIG, 8'h01);
        pins(1'b0, 1'b0);
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
        reg_chk(REG_STATUS, 8'h02);
        reg_wr(REG_CONFIG, 8'h00);
        reg_chk(REG_CONFIG, 8'h01);
        u_spps_prog_model_alt.frame(CMD_CORE, 16'h5A5A, 0);
        cmp_val(last_core, 22'h005A5A);
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
